/* rtl/lgas_top.sv */
/*
  Link group alignment status bank: four sticky status registers for
  eight receive channels, mode control, FIFO threshold and an interrupt,
  reached over APB with zero wait states.
  Assumes event inputs are one-cycle pulses or levels synchronous to pclk.
*/
// Operation
// - cell drop on pair B upper sets bit 3
// - cell drop on pair B lower sets bit 4
// - cell drop on pair A upper sets bit 5
// - cell drop on pair A lower sets bit 6
// - cell drop on eight-link group sets bit 7
// - quad B misalignment sets sync bit 1
// - pair B upper misalignment sets sync bit 2
// - pair B lower misalignment sets sync bit 3
// - quad A misalignment sets sync bit 4
// - pair A upper misalignment sets sync bit 5
// - pair A lower misalignment sets sync bit 6
// - eight-link misalignment sets sync bit 7
// - near overflow: reader below minimum at zero-write
// - quad near overflow in bits 0 and 4
// - pair near overflow in bits 2,3,5,6
// - eight-link near overflow sets bit 7
// - pair bundle alignment errors in bits 3 to 6
// - eight-link bundle alignment error sets bit 7
`timescale 1ns/1ps
`include "lgas_regs.svh"
module lgas_top
  import lgas_pkg::*;
#(
  parameter int ADDR_W  = 20,
  parameter int FIFO_AW = 4
) (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [ADDR_W-1:0]                    paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 cells_lost_pair_b_upper,
  input  wire logic                                 cells_lost_pair_b_lower,
  input  wire logic                                 cells_lost_pair_a_upper,
  input  wire logic                                 cells_lost_pair_a_lower,
  input  wire logic                                 cells_lost_eight_group,
  input  wire logic                                 unaligned_quad_b,
  input  wire logic                                 unaligned_pair_b_upper,
  input  wire logic                                 unaligned_pair_b_lower,
  input  wire logic                                 unaligned_quad_a,
  input  wire logic                                 unaligned_pair_a_upper,
  input  wire logic                                 unaligned_pair_a_lower,
  input  wire logic                                 unaligned_eight_group,
  input  wire logic                                 bundle_misalign_pair_b_upper,
  input  wire logic                                 bundle_misalign_pair_b_lower,
  input  wire logic                                 bundle_misalign_pair_a_upper,
  input  wire logic                                 bundle_misalign_pair_a_lower,
  input  wire logic                                 bundle_misalign_eight_group,
  input  wire logic [LGAS_NUM_GRP-1:0]              align_wr_en,
  input  wire logic [LGAS_NUM_GRP-1:0][FIFO_AW-1:0] align_wr_addr,
  input  wire logic [LGAS_NUM_GRP-1:0][FIFO_AW-1:0] align_rd_addr,
  output logic      [`LGAS_MODE_W-1:0]              cell_mode,
  output logic                                      irq
);

  initial begin
    if (ADDR_W < `LGAS_MIN_ADDR_W) begin
      $error("lgas_top: ADDR_W too small for the register indices");
    end
    if (FIFO_AW < 1 || FIFO_AW > 8) begin
      $error("lgas_top: FIFO_AW must lie between 1 and 8");
    end
  end

  // register state
  logic [7:0]              cell_drop_q;
  logic [7:0]              cell_drop_d;
  logic [7:0]              out_of_sync_q;
  logic [7:0]              out_of_sync_d;
  logic [7:0]              near_ovfl_q;
  logic [7:0]              near_ovfl_d;
  logic [7:0]              align_err_q;
  logic [7:0]              align_err_d;
  logic [`LGAS_MODE_W-1:0] mode_q;
  logic [FIFO_AW-1:0]      fifo_min_q;
  logic [`LGAS_IRQ_W-1:0]  irq_stat_q;
  logic [`LGAS_IRQ_W-1:0]  irq_stat_d;
  logic [`LGAS_IRQ_W-1:0]  irq_mask_q;
  logic [`LGAS_IRQ_W-1:0]  irq_new;
  logic [31:0]             prdata_q;
  logic                    pslverr_q;
  logic                    pready_q;
  logic                    irq_q;

  // decode and bus helpers
  lgas_sel_t               sel;
  logic                    setup_ph;
  logic                    wr_acc;
  logic [31:0]             rd_val;
  logic [LGAS_NUM_GRP-1:0] near_pulse;

  // mode decode: eight-link cell mode overrides the pair enables
  logic cell_all;
  logic cell_pbu;
  logic cell_pbl;
  logic cell_pau;
  logic cell_pal;
  logic son_pbu;
  logic son_pbl;
  logic son_pau;
  logic son_pal;
  logic son_qb;
  logic son_qa;
  logic son_all;
  logic [LGAS_NUM_GRP-1:0] son_grp;

  // per-pair mode, a pair is in SONET mode while no cell mode claims it
  always_comb begin
    cell_all = mode_q[`LGAS_MODE_EIGHT];
    cell_pbu = mode_q[`LGAS_MODE_PAIR_B_UPPER] & ~cell_all;
    cell_pbl = mode_q[`LGAS_MODE_PAIR_B_LOWER] & ~cell_all;
    cell_pau = mode_q[`LGAS_MODE_PAIR_A_UPPER] & ~cell_all;
    cell_pal = mode_q[`LGAS_MODE_PAIR_A_LOWER] & ~cell_all;
    son_pbu  = ~mode_q[`LGAS_MODE_PAIR_B_UPPER] & ~cell_all;
    son_pbl  = ~mode_q[`LGAS_MODE_PAIR_B_LOWER] & ~cell_all;
    son_pau  = ~mode_q[`LGAS_MODE_PAIR_A_UPPER] & ~cell_all;
    son_pal  = ~mode_q[`LGAS_MODE_PAIR_A_LOWER] & ~cell_all;
    son_qb   = son_pbu & son_pbl;
    son_qa   = son_pau & son_pal;
    son_all  = son_qa & son_qb;
    son_grp  = '0;
    son_grp[LGAS_GRP_QUAD_B]       = son_qb;
    son_grp[LGAS_GRP_PAIR_B_UPPER] = son_pbu;
    son_grp[LGAS_GRP_PAIR_B_LOWER] = son_pbl;
    son_grp[LGAS_GRP_QUAD_A]       = son_qa;
    son_grp[LGAS_GRP_PAIR_A_UPPER] = son_pau;
    son_grp[LGAS_GRP_PAIR_A_LOWER] = son_pal;
    son_grp[LGAS_GRP_EIGHT]        = son_all;
  end

  // one near-overflow detector per alignment FIFO group
  genvar g;
  generate
    for (g = 0; g < LGAS_NUM_GRP; g++) begin : g_det
      lgas_near_full_det #(
        .AW (FIFO_AW)
      ) u_det (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (align_wr_en[g]),
        .wr_addr   (align_wr_addr[g]),
        .rd_addr   (align_rd_addr[g]),
        .fifo_min  (fifo_min_q),
        .near_full (near_pulse[g])
      );
    end
  endgenerate

  // cell drop flags, sticky until reset
  always_comb begin
    cell_drop_d = cell_drop_q;
    cell_drop_d[`LGAS_CBIT_PAIR_B_UPPER] = cell_drop_q[`LGAS_CBIT_PAIR_B_UPPER]
      | (cells_lost_pair_b_upper & cell_pbu);
    cell_drop_d[`LGAS_CBIT_PAIR_B_LOWER] = cell_drop_q[`LGAS_CBIT_PAIR_B_LOWER]
      | (cells_lost_pair_b_lower & cell_pbl);
    cell_drop_d[`LGAS_CBIT_PAIR_A_UPPER] = cell_drop_q[`LGAS_CBIT_PAIR_A_UPPER]
      | (cells_lost_pair_a_upper & cell_pau);
    cell_drop_d[`LGAS_CBIT_PAIR_A_LOWER] = cell_drop_q[`LGAS_CBIT_PAIR_A_LOWER]
      | (cells_lost_pair_a_lower & cell_pal);
    cell_drop_d[`LGAS_CBIT_EIGHT] = cell_drop_q[`LGAS_CBIT_EIGHT]
      | (cells_lost_eight_group & cell_all);
  end

  // out-of-sync flags, reported only while the group runs SONET
  always_comb begin
    out_of_sync_d = out_of_sync_q;
    out_of_sync_d[`LGAS_BIT_QUAD_B_SYNC] = out_of_sync_q[`LGAS_BIT_QUAD_B_SYNC]
      | (unaligned_quad_b & son_qb);
    out_of_sync_d[`LGAS_BIT_PAIR_B_UPPER] = out_of_sync_q[`LGAS_BIT_PAIR_B_UPPER]
      | (unaligned_pair_b_upper & son_pbu);
    out_of_sync_d[`LGAS_BIT_PAIR_B_LOWER] = out_of_sync_q[`LGAS_BIT_PAIR_B_LOWER]
      | (unaligned_pair_b_lower & son_pbl);
    out_of_sync_d[`LGAS_BIT_QUAD_A] = out_of_sync_q[`LGAS_BIT_QUAD_A]
      | (unaligned_quad_a & son_qa);
    out_of_sync_d[`LGAS_BIT_PAIR_A_UPPER] = out_of_sync_q[`LGAS_BIT_PAIR_A_UPPER]
      | (unaligned_pair_a_upper & son_pau);
    out_of_sync_d[`LGAS_BIT_PAIR_A_LOWER] = out_of_sync_q[`LGAS_BIT_PAIR_A_LOWER]
      | (unaligned_pair_a_lower & son_pal);
    out_of_sync_d[`LGAS_BIT_EIGHT] = out_of_sync_q[`LGAS_BIT_EIGHT]
      | (unaligned_eight_group & son_all);
  end

  // near-overflow flags from the detectors, SONET groups only
  always_comb begin
    near_ovfl_d = near_ovfl_q;
    near_ovfl_d[`LGAS_BIT_QUAD_B] = near_ovfl_q[`LGAS_BIT_QUAD_B]
      | (near_pulse[LGAS_GRP_QUAD_B] & son_grp[LGAS_GRP_QUAD_B]);
    near_ovfl_d[`LGAS_BIT_QUAD_A] = near_ovfl_q[`LGAS_BIT_QUAD_A]
      | (near_pulse[LGAS_GRP_QUAD_A] & son_grp[LGAS_GRP_QUAD_A]);
    near_ovfl_d[`LGAS_BIT_PAIR_B_UPPER] = near_ovfl_q[`LGAS_BIT_PAIR_B_UPPER]
      | (near_pulse[LGAS_GRP_PAIR_B_UPPER]
         & son_grp[LGAS_GRP_PAIR_B_UPPER]);
    near_ovfl_d[`LGAS_BIT_PAIR_B_LOWER] = near_ovfl_q[`LGAS_BIT_PAIR_B_LOWER]
      | (near_pulse[LGAS_GRP_PAIR_B_LOWER]
         & son_grp[LGAS_GRP_PAIR_B_LOWER]);
    near_ovfl_d[`LGAS_BIT_PAIR_A_UPPER] = near_ovfl_q[`LGAS_BIT_PAIR_A_UPPER]
      | (near_pulse[LGAS_GRP_PAIR_A_UPPER]
         & son_grp[LGAS_GRP_PAIR_A_UPPER]);
    near_ovfl_d[`LGAS_BIT_PAIR_A_LOWER] = near_ovfl_q[`LGAS_BIT_PAIR_A_LOWER]
      | (near_pulse[LGAS_GRP_PAIR_A_LOWER]
         & son_grp[LGAS_GRP_PAIR_A_LOWER]);
    near_ovfl_d[`LGAS_BIT_EIGHT] = near_ovfl_q[`LGAS_BIT_EIGHT]
      | (near_pulse[LGAS_GRP_EIGHT] & son_grp[LGAS_GRP_EIGHT]);
  end

  // bundle alignment error flags, cell groups only
  always_comb begin
    align_err_d = align_err_q;
    align_err_d[`LGAS_CBIT_PAIR_B_UPPER] = align_err_q[`LGAS_CBIT_PAIR_B_UPPER]
      | (bundle_misalign_pair_b_upper & cell_pbu);
    align_err_d[`LGAS_CBIT_PAIR_B_LOWER] = align_err_q[`LGAS_CBIT_PAIR_B_LOWER]
      | (bundle_misalign_pair_b_lower & cell_pbl);
    align_err_d[`LGAS_CBIT_PAIR_A_UPPER] = align_err_q[`LGAS_CBIT_PAIR_A_UPPER]
      | (bundle_misalign_pair_a_upper & cell_pau);
    align_err_d[`LGAS_CBIT_PAIR_A_LOWER] = align_err_q[`LGAS_CBIT_PAIR_A_LOWER]
      | (bundle_misalign_pair_a_lower & cell_pal);
    align_err_d[`LGAS_CBIT_EIGHT] = align_err_q[`LGAS_CBIT_EIGHT]
      | (bundle_misalign_eight_group & cell_all);
  end

  // status registers, cleared by reset alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_drop_q   <= `LGAS_RST_STATUS;
      out_of_sync_q <= `LGAS_RST_STATUS;
      near_ovfl_q   <= `LGAS_RST_STATUS;
      align_err_q   <= `LGAS_RST_STATUS;
    end else begin
      cell_drop_q   <= cell_drop_d;
      out_of_sync_q <= out_of_sync_d;
      near_ovfl_q   <= near_ovfl_d;
      align_err_q   <= align_err_d;
    end
  end

  // address decode on the word index
  always_comb begin
    case (paddr[`LGAS_MIN_ADDR_W-1:2])
      `LGAS_IDX_CELL_DROP:     sel = LGAS_SEL_CELL_DROP;
      `LGAS_IDX_OUT_OF_SYNC:   sel = LGAS_SEL_OUT_OF_SYNC;
      `LGAS_IDX_NEAR_OVERFLOW: sel = LGAS_SEL_NEAR_OVERFLOW;
      `LGAS_IDX_ALIGN_ERROR:   sel = LGAS_SEL_ALIGN_ERROR;
      `LGAS_IDX_MODE_CTRL:     sel = LGAS_SEL_MODE_CTRL;
      `LGAS_IDX_FIFO_MIN:      sel = LGAS_SEL_FIFO_MIN;
      `LGAS_IDX_IRQ_STATUS:    sel = LGAS_SEL_IRQ_STATUS;
      `LGAS_IDX_IRQ_MASK:      sel = LGAS_SEL_IRQ_MASK;
      default:                 sel = LGAS_SEL_NONE;
    endcase
    if ((paddr >> `LGAS_MIN_ADDR_W) != '0) begin
      sel = LGAS_SEL_NONE; // upper address bits must be clear
    end
  end

  // read mux, reserved and upper bits read zero
  always_comb begin
    rd_val = `LGAS_RST_DATA;
    case (sel)
      LGAS_SEL_CELL_DROP:     rd_val[7:0] = cell_drop_q;
      LGAS_SEL_OUT_OF_SYNC:   rd_val[7:0] = out_of_sync_q;
      LGAS_SEL_NEAR_OVERFLOW: rd_val[7:0] = near_ovfl_q;
      LGAS_SEL_ALIGN_ERROR:   rd_val[7:0] = align_err_q;
      LGAS_SEL_MODE_CTRL:     rd_val[`LGAS_MODE_W-1:0] = mode_q;
      LGAS_SEL_FIFO_MIN:      rd_val[FIFO_AW-1:0] = fifo_min_q;
      LGAS_SEL_IRQ_STATUS:    rd_val[`LGAS_IRQ_W-1:0] = irq_stat_q;
      LGAS_SEL_IRQ_MASK:      rd_val[`LGAS_IRQ_W-1:0] = irq_mask_q;
      default:                rd_val = `LGAS_RST_DATA;
    endcase
  end

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & pready_q;

  // read data and error prepared in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `LGAS_RST_DATA;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= 1'b1; // zero wait states
      if (setup_ph) begin
        prdata_q  <= pwrite ? `LGAS_RST_DATA : rd_val;
        pslverr_q <= (sel == LGAS_SEL_NONE);
      end
    end
  end

  // writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= `LGAS_RST_MODE;
      fifo_min_q <= '0;
      irq_mask_q <= `LGAS_RST_IRQ;
    end else if (wr_acc) begin
      if (sel == LGAS_SEL_MODE_CTRL) begin
        mode_q <= pwdata[`LGAS_MODE_W-1:0];
      end
      if (sel == LGAS_SEL_FIFO_MIN) begin
        fifo_min_q <= pwdata[FIFO_AW-1:0];
      end
      if (sel == LGAS_SEL_IRQ_MASK) begin
        irq_mask_q <= pwdata[`LGAS_IRQ_W-1:0];
      end
    end
  end

  // interrupt events: any status bit newly set in a register
  always_comb begin
    irq_new = '0;
    irq_new[`LGAS_IRQ_CELL_DROP]     = |(cell_drop_d & ~cell_drop_q);
    irq_new[`LGAS_IRQ_OUT_OF_SYNC]   = |(out_of_sync_d & ~out_of_sync_q);
    irq_new[`LGAS_IRQ_NEAR_OVERFLOW] = |(near_ovfl_d & ~near_ovfl_q);
    irq_new[`LGAS_IRQ_ALIGN_ERROR]   = |(align_err_d & ~align_err_q);
    irq_stat_d = irq_stat_q;
    if (wr_acc && sel == LGAS_SEL_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~pwdata[`LGAS_IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | irq_new; // set wins over clear
  end

  // sticky interrupt status and masked level output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `LGAS_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign cell_mode = mode_q;
  assign irq       = irq_q;

endmodule

/* include/lgas_regs.svh */
/*
  Register indices, field positions and reset values of the link group
  alignment status bank.
  Assumes the includer maps index N to byte address 4*N on a 32-bit bus.
*/
`ifndef LGAS_REGS_SVH
`define LGAS_REGS_SVH

// register indices, byte address is four times the index
`define LGAS_IDX_W             18
`define LGAS_IDX_CELL_DROP     18'h30A0B
`define LGAS_IDX_OUT_OF_SYNC   18'h30A0C
`define LGAS_IDX_NEAR_OVERFLOW 18'h30A0D
`define LGAS_IDX_ALIGN_ERROR   18'h30A0E
`define LGAS_IDX_MODE_CTRL     18'h30A10
`define LGAS_IDX_FIFO_MIN      18'h30A11
`define LGAS_IDX_IRQ_STATUS    18'h30A12
`define LGAS_IDX_IRQ_MASK      18'h30A13

// least paddr width that reaches every index
`define LGAS_MIN_ADDR_W        20

// bit positions of the sync and near-overflow status registers, shared except for quad B
`define LGAS_BIT_QUAD_B        0
`define LGAS_BIT_QUAD_B_SYNC   1
`define LGAS_BIT_PAIR_B_UPPER  2
`define LGAS_BIT_PAIR_B_LOWER  3
`define LGAS_BIT_QUAD_A        4
`define LGAS_BIT_PAIR_A_UPPER  5
`define LGAS_BIT_PAIR_A_LOWER  6
`define LGAS_BIT_EIGHT         7
// cell registers place pair B one bit higher than the sync register, pair A at the same bits
`define LGAS_CBIT_PAIR_B_UPPER 3
`define LGAS_CBIT_PAIR_B_LOWER 4
`define LGAS_CBIT_PAIR_A_UPPER 5
`define LGAS_CBIT_PAIR_A_LOWER 6
`define LGAS_CBIT_EIGHT        7

// mode control fields: one cell enable per pair plus eight-link cell mode
`define LGAS_MODE_PAIR_A_LOWER 0
`define LGAS_MODE_PAIR_A_UPPER 1
`define LGAS_MODE_PAIR_B_LOWER 2
`define LGAS_MODE_PAIR_B_UPPER 3
`define LGAS_MODE_EIGHT        4
`define LGAS_MODE_W            5

// interrupt status bits, one per status register
`define LGAS_IRQ_CELL_DROP     0
`define LGAS_IRQ_OUT_OF_SYNC   1
`define LGAS_IRQ_NEAR_OVERFLOW 2
`define LGAS_IRQ_ALIGN_ERROR   3
`define LGAS_IRQ_W             4

// reset values
`define LGAS_RST_STATUS        8'h00
`define LGAS_RST_MODE          5'h00
`define LGAS_RST_IRQ           4'h0
`define LGAS_RST_DATA          32'h0000_0000

`endif

/* include/lgas_pkg.sv */
/*
  Types shared by the link group alignment status bank.
  Assumes lgas_regs.svh holds every register constant.
*/
package lgas_pkg;

  // register selected by the current bus address
  typedef enum logic [3:0] {
    LGAS_SEL_NONE          = 4'h0,
    LGAS_SEL_CELL_DROP     = 4'h1,
    LGAS_SEL_OUT_OF_SYNC   = 4'h3,
    LGAS_SEL_NEAR_OVERFLOW = 4'h2,
    LGAS_SEL_ALIGN_ERROR   = 4'h6,
    LGAS_SEL_MODE_CTRL     = 4'h7,
    LGAS_SEL_FIFO_MIN      = 4'h5,
    LGAS_SEL_IRQ_STATUS    = 4'h4,
    LGAS_SEL_IRQ_MASK      = 4'hC
  } lgas_sel_t;

  // alignment FIFO groups in near-overflow register order
  typedef enum logic [2:0] {
    LGAS_GRP_QUAD_B       = 3'h0,
    LGAS_GRP_PAIR_B_UPPER = 3'h1,
    LGAS_GRP_PAIR_B_LOWER = 3'h2,
    LGAS_GRP_QUAD_A       = 3'h3,
    LGAS_GRP_PAIR_A_UPPER = 3'h4,
    LGAS_GRP_PAIR_A_LOWER = 3'h5,
    LGAS_GRP_EIGHT        = 3'h6
  } lgas_grp_t;

  localparam int LGAS_NUM_GRP = 7;

endpackage

/* rtl/lgas_near_full_det.sv */
/*
  Near-overflow detector for one alignment FIFO group.
  Assumes write and read addresses are synchronous to pclk.
*/
`timescale 1ns/1ps
module lgas_near_full_det #(
  parameter int AW = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [AW-1:0] rd_addr,
  input  wire logic [AW-1:0] fifo_min,
  output logic               near_full
);

  initial begin
    if (AW < 1) begin
      $error("lgas_near_full_det: AW must be at least 1");
    end
  end

  // one-cycle pulse when location zero is written while reader lags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      near_full <= 1'b0;
    end else begin
      near_full <= wr_en && (wr_addr == '0) && (rd_addr < fifo_min);
    end
  end

endmodule

/* verification/lgas_top_asserts.sv */
/*
  Checker for the status bank: bus answer, flag setting and stickiness.
  Assumes binding to lgas_top with ADDR_W of at least 20.
*/
`timescale 1ns/1ps
`include "lgas_regs.svh"
module lgas_top_asserts #(
  parameter int ADDR_W  = 20,
  parameter int FIFO_AW = 4
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W-1:0]       paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    cells_lost_pair_b_upper,
  input wire logic                    cells_lost_eight_group,
  input wire logic                    unaligned_quad_b,
  input wire logic                    unaligned_eight_group,
  input wire logic                    bundle_misalign_pair_a_upper,
  input wire logic                    bundle_misalign_eight_group,
  input wire logic [`LGAS_MODE_W-1:0] cell_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [17:0] idx;
  logic        setup;
  logic        rd_acc;
  logic        mapped;
  logic [7:0]  seen_q;

  // bus phase decode
  assign idx    = paddr[19:2];
  assign setup  = psel && !penable;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign mapped = idx inside {[`LGAS_IDX_CELL_DROP:`LGAS_IDX_ALIGN_ERROR],
                              [`LGAS_IDX_MODE_CTRL:`LGAS_IDX_IRQ_MASK]};

  // last sync flags handed to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      seen_q <= 8'h00;
    else if (rd_acc && idx == `LGAS_IDX_OUT_OF_SYNC)
      seen_q <= prdata[7:0];
  end

  // an event in an enabled mode shows in the very next read
  property p_flag(ev, ok, r, b);
    ev && ok ##1 setup && !pwrite && idx == r |=> prdata[b];
  endproperty

  a_drop_pair_b: assert property (
    p_flag(cells_lost_pair_b_upper, cell_mode[3] && !cell_mode[4],
           `LGAS_IDX_CELL_DROP, 3)) else $error("pair b drop flag missing");
  a_drop_eight: assert property (
    p_flag(cells_lost_eight_group, cell_mode[4], `LGAS_IDX_CELL_DROP, 7))
    else $error("eight group drop flag missing");
  a_sync_quad_b: assert property (
    p_flag(unaligned_quad_b, !cell_mode[4] && !cell_mode[3] && !cell_mode[2],
           `LGAS_IDX_OUT_OF_SYNC, 1)) else $error("quad b sync flag missing");
  a_sync_eight: assert property (
    p_flag(unaligned_eight_group, cell_mode == 5'h00, `LGAS_IDX_OUT_OF_SYNC,
           7)) else $error("eight group sync flag missing");
  a_misalign_pair_a: assert property (
    p_flag(bundle_misalign_pair_a_upper, cell_mode[1] && !cell_mode[4],
           `LGAS_IDX_ALIGN_ERROR, 5)) else $error("pair a misalign missing");
  a_misalign_eight: assert property (
    p_flag(bundle_misalign_eight_group, cell_mode[4], `LGAS_IDX_ALIGN_ERROR,
           7)) else $error("eight group misalign missing");
  a_sync_sticky: assert property (
    rd_acc && idx == `LGAS_IDX_OUT_OF_SYNC |-> (prdata[7:0] & seen_q) == seen_q)
    else $error("sync flag cleared without reset");
  a_unmapped_refused: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ready_steady: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");

  // main scenarios
  c_unmapped: cover property (setup && !mapped);
  c_eight_cell: cover property (cells_lost_eight_group && cell_mode[4]);
  c_sticky_read: cover property (rd_acc && seen_q != 8'h00);
endmodule

bind lgas_top lgas_top_asserts #(.ADDR_W(ADDR_W), .FIFO_AW(FIFO_AW))
  lgas_top_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .cells_lost_pair_b_upper,
  .cells_lost_eight_group, .unaligned_quad_b, .unaligned_eight_group,
  .bundle_misalign_pair_a_upper, .bundle_misalign_eight_group, .cell_mode);

/* verification/link_group_alignment_status_bench.sv */
/*
  Bench for the status bank: APB tasks set mode and threshold, events and
  FIFO addresses are driven, flags and the interrupt are read back.
  Assumes the design answers each access within a few cycles.
*/
`timescale 1ns/1ps
`include "lgas_regs.svh"
module link_group_alignment_status_bench
  import lgas_pkg::*;
;
  localparam logic [17:0] CDR = `LGAS_IDX_CELL_DROP;
  localparam logic [17:0] OOS = `LGAS_IDX_OUT_OF_SYNC;
  localparam logic [17:0] NOV = `LGAS_IDX_NEAR_OVERFLOW;
  localparam logic [17:0] AER = `LGAS_IDX_ALIGN_ERROR;
  localparam logic [17:0] IST = `LGAS_IDX_IRQ_STATUS;
  localparam logic [17:0] IMK = `LGAS_IDX_IRQ_MASK;

  logic                    pclk      = 1'b0;
  logic                    presetn   = 1'b0;
  logic                    psel      = 1'b0;
  logic                    penable   = 1'b0;
  logic                    pwrite    = 1'b0;
  logic [19:0]             paddr     = 20'h0;
  logic [31:0]             pwdata    = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [4:0]              drop      = 5'h0;
  logic [4:0]              mis       = 5'h0;
  logic [6:0]              oos       = 7'h0;
  logic [6:0]              wen       = 7'h0;
  logic [6:0][3:0]         wa        = '0;
  logic [6:0][3:0]         ra        = '0;
  logic [4:0]              cmode;
  logic                    irq;
  logic [31:0]             rdat;
  logic                    rerr;
  int                      err_count = 0;
  int                      checks    = 0;

  // 125 MHz clock
  always #4 pclk = ~pclk;

  lgas_top #(.ADDR_W(20), .FIFO_AW(4)) lgas_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .cell_mode(cmode),
    .cells_lost_pair_b_upper(drop[0]), .cells_lost_pair_b_lower(drop[1]),
    .cells_lost_pair_a_upper(drop[2]), .cells_lost_pair_a_lower(drop[3]),
    .cells_lost_eight_group(drop[4]), .unaligned_quad_b(oos[0]),
    .unaligned_pair_b_upper(oos[1]), .unaligned_pair_b_lower(oos[2]),
    .unaligned_quad_a(oos[3]), .unaligned_pair_a_upper(oos[4]),
    .unaligned_pair_a_lower(oos[5]), .unaligned_eight_group(oos[6]),
    .bundle_misalign_pair_b_upper(mis[0]),
    .bundle_misalign_pair_b_lower(mis[1]),
    .bundle_misalign_pair_a_upper(mis[2]),
    .bundle_misalign_pair_a_lower(mis[3]),
    .bundle_misalign_eight_group(mis[4]), .align_wr_en(wen),
    .align_wr_addr(wa), .align_rd_addr(ra));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [17:0] ix,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {ix, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [17:0] ix,
                    input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    chk(name, rdat, exp);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    do_reset();
    // reset values, index 0x30A0F is the unmapped hole
    for (int i = 0; i < 9; i++) begin
      rd("reset value", 18'(CDR + i), 32'h0);
      chk("slverr", 32'(rerr), 32'(i == 4));
    end
    // cell groups one at a time, pair events too in eight-link mode
    for (int i = 0; i < 5; i++) begin
      do_reset();
      apb(1'b1, `LGAS_IDX_MODE_CTRL, (i < 4) ? 32'h0F : 32'h10);
      @(posedge pclk);
      chk("cell mode", 32'(cmode), (i < 4) ? 32'h0F : 32'h10);
      drop <= (i < 4) ? 5'(1 << i) : 5'h1F;
      mis  <= (i < 4) ? 5'(1 << i) : 5'h1F;
      oos  <= 7'h7F;
      rd("drop", CDR, 32'(8 << i));
      rd("align", AER, 32'(8 << i));
      rd("sync in cell", OOS, 32'h0);
      drop <= 5'h0;
      mis  <= 5'h0;
      oos  <= 7'h0;
      rd("drop kept", CDR, 32'(8 << i));
    end
    // sync groups one at a time in SONET mode
    for (int i = 0; i < 7; i++) begin
      do_reset();
      @(posedge pclk);
      oos <= 7'(1 << i);
      rd("sync", OOS, 32'(2 << i));
      oos <= 7'h0;
      rd("sync kept", OOS, 32'(2 << i));
    end
    // only pair a lower in cell mode: its quad and eight stay SONET-blind
    do_reset();
    apb(1'b1, `LGAS_IDX_MODE_CTRL, 32'h01);
    @(posedge pclk);
    oos  <= 7'h7F;
    drop <= 5'h1F;
    rd("mixed sync", OOS, 32'h2E);
    rd("mixed drop", CDR, 32'h40);
    oos  <= 7'h0;
    drop <= 5'h0;
    // threshold boundary, then a true near-overflow per group
    for (int g = 0; g < LGAS_NUM_GRP; g++) begin
      do_reset();
      apb(1'b1, `LGAS_IDX_FIFO_MIN, 32'h4);
      @(posedge pclk);
      wen[g] <= 1'b1;
      ra[g]  <= 4'h4;
      @(posedge pclk);
      wa[g]  <= 4'h1;
      ra[g]  <= 4'h0;
      @(posedge pclk);
      wen[g] <= 1'b0;
      rd("no near full", NOV, 32'h0);
      @(posedge pclk);
      wen[g] <= 1'b1;
      wa[g]  <= 4'h0;
      ra[g]  <= 4'h3;
      @(posedge pclk);
      wen[g] <= 1'b0;
      rd("near full", NOV, (g == 0) ? 32'h1 : 32'(2 << g));
    end
    // interrupt masked, raised, cleared; the flag outlives the clear
    do_reset();
    @(posedge pclk);
    oos <= 7'h01;
    @(posedge pclk);
    oos <= 7'h00;
    repeat (2) @(posedge pclk);
    #1 chk("irq masked", 32'(irq), 32'h0);
    rd("irq status", IST, 32'h2);
    apb(1'b1, IMK, 32'h2);
    repeat (2) @(posedge pclk);
    #1 chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, OOS, 32'hFF);
    chk("status write slverr", 32'(rerr), 32'h0);
    apb(1'b1, IST, 32'h2);
    repeat (2) @(posedge pclk);
    #1 chk("irq cleared", 32'(irq), 32'h0);
    rd("irq status", IST, 32'h0);
    rd("sync kept", OOS, 32'h2);
    wrap_up();
  end

  // cuts a hang short
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
endmodule
